// [test/tone_timers_buzzer_mix_bench.sv]
/* Self-checking bench for ttb_top with a piezo stand-in.
   Assumes the register map of ttb_map.vh and a 25 MHz SYS_CLK. */
`include "ttb_map.vh"
`timescale 1ns/1ns
`default_nettype none
module tone_timers_buzzer_mix_bench;
  logic sys_clk = 0, rst = 1, wr = 0, rd = 0, fast = 0, dir = 0;
  logic slow = 0, rc = 0;
  logic [7:0] addr = 0, wdata = 0, v;
  logic [7:0] ra[7] = '{1, 5, 9, 2, 8'h2B, 8'h3C, 8'h3F};
  logic [7:0] rv[7] = '{8'h10, 8'h10, 8'h10, 0, 0, 0, 0};
  wire [7:0] rdata;
  wire buz, irq;
  wire [2:0] uf;
  int errors = 0, compares = 0, ufc[3] = '{0, 0, 0}, edges, n, e0, u0, p;
  always #20 sys_clk = ~sys_clk;
  // Fast oscillator period is 8 system cycles
  always #160 fast = ~fast;
  // Slow clock sped up to 16 cycles so slow taps fit the run
  always #320 slow = ~slow;
  // RC input period is 10 system cycles
  always #200 rc = ~rc;
  ttb_top dut (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .LOW_FREQ_CLOCK(slow),
    .FAST_OSC_CLOCK(fast), .RC_OSC_INPUT(rc),
    .DIRECT_TOGGLE_CLOCK(dir), .BUZZER_DRIVE_BIT(buz), .UNDERFLOW(uf),
    .IRQ(irq));
  ttb_piezo pz (.drive(buz), .edges(edges));
  always @(negedge sys_clk)
    for (int i = 0; i < 3; i++)
      if (uf[i] === 1'b1)
        ufc[i]++;
  function int tick(int t, int c);
    return 8 << ((t == 2 ? 17 : 15) - c);
  endfunction
  task chk(input string nm, input [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task wreg(input int a, d);
    @(posedge sys_clk);
    addr <= a[7:0];
    wdata <= d[7:0];
    wr <= 1;
    @(posedge sys_clk);
    wr <= 0;
  endtask
  task rreg(input int a, output [7:0] d);
    @(posedge sys_clk);
    addr <= a[7:0];
    rd <= 1;
    @(posedge sys_clk);
    rd <= 0;
    #1 d = rdata;
  endtask
  task run(input int a, m, d);
    wreg(a + 2, 0);
    wreg(a + 1, m);
    wreg(a, d);
    wreg(a + 2, 1);
  endtask
  task halt;
    wreg(2, 0);
    wreg(6, 0);
    wreg(10, 0);
  endtask
  // Second gap is measured, the first may be a tick off
  task per(input int i, output int q);
    repeat (2) begin
      q = 1;
      @(negedge sys_clk);
      while (uf[i] !== 1'b1 && q < 20000) begin
        @(negedge sys_clk);
        q++;
      end
    end
  endtask
  task sync(input int i);
    int k;
    k = ufc[i];
    repeat (2000)
      if (ufc[i] == k)
        @(negedge sys_clk);
    repeat (5) @(negedge sys_clk);
  endtask
  task mix_run(input int i, k);
    sync(i);
    e0 = edges;
    u0 = ufc[i];
    repeat (8) sync(i);
    chk("buzzer edges", k * (ufc[i] - u0), edges - e0);
  endtask
  task stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #3000000;
    errors++;
    stop_test;
  end
  initial begin
    n = $urandom(32'h92B2A093);
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    for (int j = 0; j < 7; j++) begin
      rreg(ra[j], v);
      chk("reset value", rv[j], v);
    end
    wreg(0, 8'h05);
    rreg(0, v);
    chk("count read", 0, v);
    $display("registers test done");
    for (int c = 8; c < 16; c++) begin
      run(0, {4'h1, c[3:0]}, 1);
      per(0, p);
      chk("t0 period", 2 * tick(0, c), p);
    end
    for (int c = 14; c < 16; c++) begin
      run(8, {4'h1, c[3:0]}, 1);
      per(2, p);
      chk("t2 period", 2 * tick(2, c), p);
    end
    repeat (3) begin
      n = 1 + $urandom % 7;
      run(0, 8'h1F, n);
      per(0, p);
      chk("reload period", (n + 1) * tick(0, 15), p);
    end
    run(0, 8'h1F, 8'hFF);
    run(4, 8'h10, 1);
    per(1, p);
    chk("cascade period", 512 * tick(0, 15), p);
    run(4, 8'h1F, 8'hFF);
    run(8, 8'h10, 1);
    per(2, p);
    chk("t2 cascade period", 512 * tick(0, 15), p);
    run(0, 8'h17, 1);
    per(0, p);
    chk("slow tap period", 2 * (16 << 6), p);
    run(0, 8'h10, 1);
    per(0, p);
    chk("rc period", 2 * 10, p);
    run(0, 8'h90, 1);
    repeat (100) @(negedge sys_clk);
    e0 = ufc[0];
    repeat (200) @(negedge sys_clk);
    chk("stopped events", e0, ufc[0]);
    $display("clock test done");
    halt;
    run(0, 8'h0F, 3);
    e0 = ufc[0];
    repeat (300) @(negedge sys_clk);
    chk("one-shot events", e0 + 1, ufc[0]);
    rreg(0, v);
    chk("one-shot count", 0, v);
    $display("one-shot test done");
    wreg(`TTB_ADR_MIX, 8'h10);
    run(4, 8'h1F, 2);
    mix_run(1, 0);
    wreg(`TTB_ADR_MIX, 8'h00);
    mix_run(1, 1);
    wreg(6, 0);
    run(0, 8'h1F, 2);
    wreg(`TTB_ADR_MIX, 8'h10);
    mix_run(0, 1);
    wreg(`TTB_ADR_MIX, 8'h20);
    repeat (20) @(negedge sys_clk);
    e0 = edges;
    repeat (4) begin
      @(posedge sys_clk);
      dir <= ~dir;
      repeat (20) @(posedge sys_clk);
    end
    chk("direct edges", 4, edges - e0);
    $display("buzzer test done");
    chk("masked irq", 0, irq);
    wreg(`TTB_ADR_IRQ_MASK, 1);
    repeat (3) @(negedge sys_clk);
    chk("irq raised", 1, irq);
    halt;
    wreg(`TTB_ADR_IRQ_STAT, 7);
    repeat (3) @(negedge sys_clk);
    chk("irq cleared", 0, irq);
    $display("interrupt test done");
    stop_test;
  end
endmodule // tone_timers_buzzer_mix_bench
`default_nettype wire

// [test/ttb_asserts.sv]
/* Port checker for ttb_top, bound into the design.
   Assumes the register map of ttb_map.vh. */
`include "ttb_map.vh"
`timescale 1ns/1ns
`default_nettype none
module ttb_asserts (
  // System
  input wire logic SYS_CLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // Buzzer and events
  input wire logic DIRECT_TOGGLE_CLOCK,
  input wire logic BUZZER_DRIVE_BIT,
  input wire logic [2:0] UNDERFLOW,
  input wire logic IRQ
);
  logic [1:0] mix;
  logic [2:0] ufh;
  logic run;
  // Registers are hidden, so shadow them from writes
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      mix <= 2'h0;
      ufh <= 3'h0;
      run <= 1'b0;
    end else begin
      ufh <= {ufh[1:0], |UNDERFLOW};
      if (WR && ADDR == `TTB_ADR_MIX)
        mix <= WDATA[5:4];
      if (WR && ADDR[1:0] == 2'h2 && ADDR < 8'h0C && WDATA[0])
        run <= 1'b1;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  property p_rd_idle; !RD |=> RDATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_mix_rd;
    RD && ADDR == `TTB_ADR_MIX |=> RDATA == {2'h0, mix, 4'h0};
  endproperty
  a_mix_rd: assert property (p_mix_rd) else $error("mix readback");
  property p_uf_pulse;
    UNDERFLOW != 3'h0 |=> (UNDERFLOW & $past(UNDERFLOW)) == 3'h0;
  endproperty
  a_uf_pulse: assert property (p_uf_pulse) else $error("long pulse");
  property p_quiet; !run |-> UNDERFLOW == 3'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("underflow while off");
  property p_single;
    mix == 2'h1 && $past(mix) == 2'h1 && UNDERFLOW[0]
      |-> ##[0:3] $changed(BUZZER_DRIVE_BIT);
  endproperty
  a_single: assert property (p_single) else $error("no toggle");
  property p_dual;
    mix == 2'h0 && $past(mix, 4) == 2'h0 && $changed(BUZZER_DRIVE_BIT)
      |-> ufh != 3'h0 || UNDERFLOW != 3'h0;
  endproperty
  a_dual: assert property (p_dual) else $error("toggle without cause");
  property p_direct;
    mix[1] && $rose(DIRECT_TOGGLE_CLOCK) |-> ##[1:8] BUZZER_DRIVE_BIT;
  endproperty
  a_direct: assert property (p_direct) else $error("direct lost");
  property p_irq;
    $rose(IRQ) |-> ufh != 3'h0 || $past(WR) || $past(WR, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without event");
  c_uf: cover property (UNDERFLOW[0]);
  c_irq: cover property ($rose(IRQ));
  c_dir: cover property (mix[1] && $changed(BUZZER_DRIVE_BIT));
endmodule // ttb_asserts
bind ttb_top ttb_asserts u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .DIRECT_TOGGLE_CLOCK(DIRECT_TOGGLE_CLOCK),
  .BUZZER_DRIVE_BIT(BUZZER_DRIVE_BIT), .UNDERFLOW(UNDERFLOW), .IRQ(IRQ));
`default_nettype wire

// [test/ttb_piezo.sv]
/* Piezo stand-in: counts level changes of the buzzer drive.
   Assumes a clean registered drive level. */
`timescale 1ns/1ns
`default_nettype none
module ttb_piezo (
  // Buzzer pin
  input wire logic drive,
  // Activity seen
  output var int edges
);
  initial edges = 0;
  // Time zero skipped, the X to 0 start is no swing
  always @(drive)
    if ($time > 0)
      edges++;
endmodule // ttb_piezo
`default_nettype wire

// [verilog/ttb_map.vh]
/*
  Register map, field positions, reset values and system clock rate of the
  tone timer and buzzer mixer block.
  Assumes plain-port register access, byte-wide data, 25 MHz system clock.
*/
// Behaviour
// - Mix bit one: channel from timer0 toggle only
// - Mix bit zero: join timer0 and timer1 toggles
// - Source bit picks direct toggle clock or channel
// - Each timer: 8-bit latch and down counter
// - Mode bit: reload when one, one-shot otherwise
// - Reload period is latch plus one ticks
// - Reaching zero emits an underflow pulse
// - First period after enable may be one tick off
// - Count write loads latch, read returns counter
// - Timer0 clock select decode table
// - Timer1 code 000x cascades from timer0 bit 7
// - Timer2 code 000x cascades from timer1 bit 7
// - Timer2 fast codes pick taps 8 down to 1
// - Timer0 stop mode selects stopping event
// - Taps divide slow and fast clocks by powers of two
// - Enable bit zero starts and stops counting
`ifndef TTB_MAP_VH
`define TTB_MAP_VH
`define TTB_ADR_T0_COUNT 8'h00
`define TTB_ADR_T0_MODE 8'h01
`define TTB_ADR_T0_EN 8'h02
`define TTB_ADR_T1_COUNT 8'h04
`define TTB_ADR_T1_MODE 8'h05
`define TTB_ADR_T1_EN 8'h06
`define TTB_ADR_T2_COUNT 8'h08
`define TTB_ADR_T2_MODE 8'h09
`define TTB_ADR_T2_EN 8'h0A
`define TTB_ADR_MIX 8'h2B
`define TTB_ADR_IRQ_STAT 8'h3C
`define TTB_ADR_IRQ_MASK 8'h3D
`define TTB_BIT_RELOAD 4
`define TTB_BIT_STOP_HI 7
`define TTB_BIT_STOP_LO 6
`define TTB_BIT_MIX_SINGLE 4
`define TTB_BIT_MIX_DIRECT 5
`define TTB_RST_MODE 8'h10
`define TTB_RST_MIX 8'h00
`define TTB_STOP_OFF 2'h0
`define TTB_STOP_T2_UNDER 2'h1
`define TTB_STOP_RC_CYCLE 2'h2
`define TTB_STOP_T2_CLOCK 2'h3
`define TTB_SYS_CLK_HZ 25000000
`endif

// [verilog/ttb_top.v]
/*
  Three 8-bit tone timers with clock select, reload / one-shot, Timer0
  stop modes, two channel toggles and a buzzer source mixer.
  Assumes low_freq_clock, fast_osc_clock and rc_osc_input arrive from
  outside SYS_CLK's domain and are each well below half its rate.
*/
// Our own choice: the plain strobed port.
`include "ttb_map.vh"
`timescale 1ns/1ns
`default_nettype none
module ttb_top (
  // System
  input wire SYS_CLK,
  input wire RST,
  // Register port
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  // Clock sources
  input wire LOW_FREQ_CLOCK,
  input wire FAST_OSC_CLOCK,
  input wire RC_OSC_INPUT,
  // Direct toggle clock for the buzzer
  input wire DIRECT_TOGGLE_CLOCK,
  // Outputs
  output reg BUZZER_DRIVE_BIT,
  output reg [2:0] UNDERFLOW,
  output reg IRQ
);
  // Three-stage sampler, change accepted once stages two and three agree
  reg [2:0] s_slow, s_fast, s_rc, s_dir;
  reg slow_q, fast_q, rc_q, dir_q;
  reg slow_prev, fast_prev, rc_prev;
  wire slow_rise = slow_q & ~slow_prev;
  wire fast_rise = fast_q & ~fast_prev;
  wire rc_rise = rc_q & ~rc_prev;
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_slow <= 3'h0;
      s_fast <= 3'h0;
      s_rc <= 3'h0;
      s_dir <= 3'h0;
      slow_q <= 1'b0;
      fast_q <= 1'b0;
      rc_q <= 1'b0;
      dir_q <= 1'b0;
      slow_prev <= 1'b0;
      fast_prev <= 1'b0;
      rc_prev <= 1'b0;
    end else begin
      s_slow <= {s_slow[1:0], LOW_FREQ_CLOCK};
      s_fast <= {s_fast[1:0], FAST_OSC_CLOCK};
      s_rc <= {s_rc[1:0], RC_OSC_INPUT};
      s_dir <= {s_dir[1:0], DIRECT_TOGGLE_CLOCK};
      if (s_slow[1] == s_slow[2])
        slow_q <= s_slow[2];
      if (s_fast[1] == s_fast[2])
        fast_q <= s_fast[2];
      if (s_rc[1] == s_rc[2])
        rc_q <= s_rc[2];
      if (s_dir[1] == s_dir[2])
        dir_q <= s_dir[2];
      slow_prev <= slow_q;
      fast_prev <= fast_q;
      rc_prev <= rc_q;
    end
  end

  // Ripple-style dividers: tap n toggles at source / 2^(n+1)
  reg [13:0] slow_div;
  reg [8:0] fast_div;
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      slow_div <= 14'h0000;
      fast_div <= 9'h000;
    end else begin
      if (slow_rise)
        slow_div <= slow_div + 14'h0001;
      if (fast_rise)
        fast_div <= fast_div + 9'h001;
    end
  end

  // Tick on the rising edge of a tap; prev copy of each counter bit
  reg [13:0] slow_div_d;
  reg [8:0] fast_div_d;
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      slow_div_d <= 14'h0000;
      fast_div_d <= 9'h000;
    end else begin
      slow_div_d <= slow_div;
      fast_div_d <= fast_div;
    end
  end
  wire [13:0] slow_tick = slow_div & ~slow_div_d;
  wire [8:0] fast_tick = fast_div & ~fast_div_d;

  // Shared slow-tap decode for codes 001x and 01xx
  function slow_pick;
    input [3:0] sel;
    input [13:0] t;
    begin
      case (sel[2:0])
        3'h2, 3'h3: slow_pick = t[13];
        3'h4: slow_pick = t[11];
        3'h5: slow_pick = t[9];
        3'h6: slow_pick = t[7];
        3'h7: slow_pick = t[5];
        default: slow_pick = 1'b0;
      endcase
    end
  endfunction

  // Fast tap for timers 0/1: 1000..1110 taps 6..0, 1111 raw oscillator
  function fast01_pick;
    input [3:0] sel;
    input [8:0] t;
    input raw;
    begin
      if (sel[2:0] == 3'h7)
        fast01_pick = raw;
      else
        fast01_pick = t[3'h6 - sel[2:0]];
    end
  endfunction

  // Registers
  reg [7:0] latch0, latch1, latch2;
  reg [7:0] cnt0, cnt1, cnt2;
  reg [7:0] mode0, mode1, mode2;
  reg en0, en1, en2;
  reg [7:0] mix;
  reg [2:0] irq_stat, irq_mask;
  reg [2:0] reload_req;
  reg [2:0] done;
  reg t0_stopped;
  reg stop_armed;
  reg ch0, ch1;
  reg cnt0_b7_d, cnt1_b7_d;

  wire wr_c0 = WR && ADDR == `TTB_ADR_T0_COUNT;
  wire wr_c1 = WR && ADDR == `TTB_ADR_T1_COUNT;
  wire wr_c2 = WR && ADDR == `TTB_ADR_T2_COUNT;
  wire wr_e0 = WR && ADDR == `TTB_ADR_T0_EN;
  wire wr_e1 = WR && ADDR == `TTB_ADR_T1_EN;
  wire wr_e2 = WR && ADDR == `TTB_ADR_T2_EN;

  // Cascade ticks from rising edges of the previous counter's bit 7
  wire casc0 = cnt0[7] & ~cnt0_b7_d;
  wire casc1 = cnt1[7] & ~cnt1_b7_d;

  wire [3:0] sel0 = mode0[3:0];
  wire [3:0] sel1 = mode1[3:0];
  wire [3:0] sel2 = mode2[3:0];
  reg tick0, tick1, tick2;
  always @* begin
    if (sel0[3:1] == 3'h0)
      tick0 = rc_rise;
    else if (!sel0[3])
      tick0 = slow_pick(sel0, slow_tick);
    else
      tick0 = fast01_pick(sel0, fast_tick, fast_rise);
    if (sel1[3:1] == 3'h0)
      tick1 = casc0;
    else if (!sel1[3])
      tick1 = slow_pick(sel1, slow_tick);
    else
      tick1 = fast01_pick(sel1, fast_tick, fast_rise);
    if (sel2[3:1] == 3'h0)
      tick2 = casc1;
    else if (!sel2[3])
      tick2 = slow_pick(sel2, slow_tick);
    else
      tick2 = fast_tick[4'h8 - {1'b0, sel2[2:0]}];
  end

  // Counter step: decrement, underflow at zero, reload or hold
  wire run0 = en0 & ~t0_stopped & tick0;
  wire run1 = en1 & tick1;
  wire run2 = en2 & tick2;
  // Underflow when a nonzero count steps to zero
  wire uf0 = run0 & ~done[0] & (cnt0 == 8'h01);
  wire uf1 = run1 & ~done[1] & (cnt1 == 8'h01);
  wire uf2 = run2 & ~done[2] & (cnt2 == 8'h01);

  // Stop mode, cleared on enable of Timer0
  wire [1:0] stop_mode = mode0[`TTB_BIT_STOP_HI:`TTB_BIT_STOP_LO];
  reg stop_event;
  always @* begin
    case (stop_mode)
      `TTB_STOP_T2_UNDER: stop_event = uf2;
      `TTB_STOP_RC_CYCLE: stop_event = rc_rise & stop_armed;
      `TTB_STOP_T2_CLOCK: stop_event = tick2 & stop_armed;
      default: stop_event = 1'b0;
    endcase
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      latch0 <= 8'h00;
      latch1 <= 8'h00;
      latch2 <= 8'h00;
      cnt0 <= 8'h00;
      cnt1 <= 8'h00;
      cnt2 <= 8'h00;
      mode0 <= `TTB_RST_MODE;
      mode1 <= `TTB_RST_MODE;
      mode2 <= `TTB_RST_MODE;
      en0 <= 1'b0;
      en1 <= 1'b0;
      en2 <= 1'b0;
      mix <= `TTB_RST_MIX;
      irq_mask <= 3'h0;
      reload_req <= 3'h0;
      done <= 3'h0;
      t0_stopped <= 1'b0;
      stop_armed <= 1'b0;
      cnt0_b7_d <= 1'b0;
      cnt1_b7_d <= 1'b0;
    end else begin
      cnt0_b7_d <= cnt0[7];
      cnt1_b7_d <= cnt1[7];
      if (WR && ADDR == `TTB_ADR_T0_MODE)
        mode0 <= WDATA;
      if (WR && ADDR == `TTB_ADR_T1_MODE)
        mode1 <= WDATA;
      if (WR && ADDR == `TTB_ADR_T2_MODE)
        mode2 <= WDATA;
      if (WR && ADDR == `TTB_ADR_MIX)
        mix <= WDATA;
      if (WR && ADDR == `TTB_ADR_IRQ_MASK)
        irq_mask <= WDATA[2:0];
      if (wr_e0)
        en0 <= WDATA[0];
      if (wr_e1)
        en1 <= WDATA[0];
      if (wr_e2)
        en2 <= WDATA[0];
      // Latch write; counter picks it up on the next selected tick
      if (wr_c0)
        latch0 <= WDATA;
      if (wr_c1)
        latch1 <= WDATA;
      if (wr_c2)
        latch2 <= WDATA;
      // Enable not aligned to the tick: first period may be short
      reload_req[0] <= (reload_req[0] & ~run0) | wr_c0 |
        (wr_e0 & WDATA[0]);
      reload_req[1] <= (reload_req[1] & ~run1) | wr_c1 |
        (wr_e1 & WDATA[0]);
      reload_req[2] <= (reload_req[2] & ~run2) | wr_c2 |
        (wr_e2 & WDATA[0]);
      if (run0) begin
        if (reload_req[0] || (cnt0 == 8'h00 &&
            mode0[`TTB_BIT_RELOAD])) begin
          cnt0 <= latch0;
          done[0] <= 1'b0;
        end else if (cnt0 != 8'h00) begin
          cnt0 <= cnt0 - 8'h01;
        end else begin
          done[0] <= 1'b1;
        end
      end
      if (run1) begin
        if (reload_req[1] || (cnt1 == 8'h00 &&
            mode1[`TTB_BIT_RELOAD])) begin
          cnt1 <= latch1;
          done[1] <= 1'b0;
        end else if (cnt1 != 8'h00) begin
          cnt1 <= cnt1 - 8'h01;
        end else begin
          done[1] <= 1'b1;
        end
      end
      if (run2) begin
        if (reload_req[2] || (cnt2 == 8'h00 &&
            mode2[`TTB_BIT_RELOAD])) begin
          cnt2 <= latch2;
          done[2] <= 1'b0;
        end else if (cnt2 != 8'h00) begin
          cnt2 <= cnt2 - 8'h01;
        end else begin
          done[2] <= 1'b1;
        end
      end
      // Stop mode: re-enable clears it; mode 2/3 need one full cycle
      if (wr_e0 & WDATA[0]) begin
        t0_stopped <= 1'b0;
        stop_armed <= 1'b0;
      end else begin
        if (stop_mode == `TTB_STOP_RC_CYCLE && rc_rise && en0)
          stop_armed <= 1'b1;
        if (stop_mode == `TTB_STOP_T2_CLOCK && tick2 && en0)
          stop_armed <= 1'b1;
        if (en0 && stop_event)
          t0_stopped <= 1'b1;
      end
    end
  end

  // Channel toggles, interrupt status, buzzer mix
  wire [2:0] uf_vec = {uf2, uf1, uf0};
  wire single_ch = mix[`TTB_BIT_MIX_SINGLE];
  // Single mode uses ch0 alone as the combined channel; ch1 is ignored
  wire combined_channel = single_ch ? ch0 : (ch0 ^ ch1);
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ch0 <= 1'b0;
      ch1 <= 1'b0;
      irq_stat <= 3'h0;
      UNDERFLOW <= 3'h0;
      BUZZER_DRIVE_BIT <= 1'b0;
      IRQ <= 1'b0;
      RDATA <= 8'h00;
    end else begin
      if (uf0)
        ch0 <= ~ch0;
      if (uf1)
        ch1 <= ~ch1;
      UNDERFLOW <= uf_vec;
      // Set wins over a write-one clear in the same cycle
      if (WR && ADDR == `TTB_ADR_IRQ_STAT)
        irq_stat <= (irq_stat & ~WDATA[2:0]) | uf_vec;
      else
        irq_stat <= irq_stat | uf_vec;
      IRQ <= |(irq_stat & irq_mask);
      BUZZER_DRIVE_BIT <= mix[`TTB_BIT_MIX_DIRECT] ? dir_q :
        combined_channel;
      if (RD) begin
        case (ADDR)
          `TTB_ADR_T0_COUNT: RDATA <= cnt0;
          `TTB_ADR_T1_COUNT: RDATA <= cnt1;
          `TTB_ADR_T2_COUNT: RDATA <= cnt2;
          `TTB_ADR_T0_MODE: RDATA <= mode0;
          `TTB_ADR_T1_MODE: RDATA <= {3'h0, mode1[4:0]};
          `TTB_ADR_T2_MODE: RDATA <= {3'h0, mode2[4:0]};
          `TTB_ADR_T0_EN: RDATA <= {7'h00, en0};
          `TTB_ADR_T1_EN: RDATA <= {7'h00, en1};
          `TTB_ADR_T2_EN: RDATA <= {7'h00, en2};
          `TTB_ADR_MIX: RDATA <= {2'h0, mix[5:4], 4'h0};
          `TTB_ADR_IRQ_STAT: RDATA <= {5'h00, irq_stat};
          `TTB_ADR_IRQ_MASK: RDATA <= {5'h00, irq_mask};
          default: RDATA <= 8'h00;
        endcase
      end else begin
        RDATA <= 8'h00;
      end
    end
  end
endmodule // ttb_top
`default_nettype wire
